// file: cbg_bus_model.sv
// Processor side model: address and request lines of access cycles.
// Assumes calls from a bench that drives on the falling clock edge.
`timescale 1ns/1ps
`default_nettype none
module cbg_bus_model (
	input  wire logic       clk_in,
	output logic [2:0]      addr_out,
	output logic            mreq_n_out,
	output logic            iorq_n_out
);
	initial begin
		addr_out = 3'h0;
		mreq_n_out = 1'b1;
		iorq_n_out = 1'b1;
	end
	// Cycle starts at a falling edge and holds until the next call
	task automatic access(input logic [2:0] a, input logic mem, input logic io);
		@(negedge clk_in);
		addr_out = (mem | io) ? a : ~a;
		mreq_n_out = ~mem;
		iorq_n_out = ~io;
	endtask
endmodule
`default_nettype wire

// file: cbg_defines.svh
// Constants for the processor board glue logic.
// Assumes a 25 MHz oscillator on clk_in; included by its bare name.
//
// Behaviour
// - Processor clock: oscillator halved, two complementary phases
// - Selects decoded from the three address bits on addr_in
// - Exactly one select low per decoded address
// - Power-up holds processor system in reset
// - Watchdog resets processor unless firmware services it
// - Failing supply pulls the warning low and resets processor in the same cycle
// - Backup battery condition reported to processor
// - Logic supply status readable on parallel port line
// - Four analog channels through one converter, bus-readable
// - Interlock checks switch requests for forbidden combinations
// - Safe signal only when no forbidden combination
// - Interlock is hardware, independent of firmware
// - Selects and port outputs held in flip-flops
`ifndef CBG_DEFINES_SVH
`define CBG_DEFINES_SVH

`define CBG_CLK_KHZ      25000
`define CBG_POR_MS       200
`define CBG_WD_MS        1600
`define CBG_CNT_W        26
`define CBG_SEL_IDLE     8'hff
`define CBG_PORT_RST     8'h00
`define CBG_PORT_STAT_B  7
`define CBG_ADC_CHANS    4

`endif

// file: cbg_glue.sv
// Processor board glue: clock divider, select decode, supervisor,
// parallel port latches, converter result store and safety interlock.
// Assumes all inputs synchronous to clk_in, the oscillator clock.
`include "cbg_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module cbg_glue #(
	parameter int unsigned POR_CYCLES = `CBG_POR_MS * `CBG_CLK_KHZ,
	parameter int unsigned WD_CYCLES  = `CBG_WD_MS * `CBG_CLK_KHZ
) (
	input  wire logic       clk_in,
	input  wire logic       nrst_in,
	input  wire logic [2:0] addr_in,
	input  wire logic       mreq_n_in,
	input  wire logic       iorq_n_in,
	input  wire logic       wd_kick_in,
	input  wire logic       supply_fail_in,
	input  wire logic       batt_low_in,
	input  wire logic       logic_ok_in,
	input  wire logic       port_wr_in,
	input  wire logic       port_dir_sel_in,
	input  wire logic [7:0] port_wdata_in,
	input  wire logic [7:0] port_pins_in,
	input  wire logic       conv_valid_in,
	input  wire logic [7:0] conv_data_in,
	input  wire logic [1:0] adc_rd_chan_in,
	input  wire logic [3:0] foot_req_in,
	input  wire logic [3:0] finger_req_in,
	output logic            phi_out,
	output logic            phi_n_out,
	output logic [7:0]      sel_n_out,
	output logic            cpu_rst_n_out,
	output logic            pwr_warn_n_out,
	output logic            batt_low_out,
	output logic [7:0]      port_out,
	output logic [7:0]      port_oe_out,
	output logic [7:0]      port_rd_data_out,
	output logic [1:0]      conv_chan_out,
	output logic [7:0]      adc_rd_data_out,
	output logic [7:0]      act_out,
	output logic            safe_out
);

	localparam logic [`CBG_CNT_W-1:0] POR_LIM = `CBG_CNT_W'(POR_CYCLES - 1);
	localparam logic [`CBG_CNT_W-1:0] WD_LIM  = `CBG_CNT_W'(WD_CYCLES - 1);

	cbg_pkg::cbg_sup_state_type state_reg;
	cbg_pkg::cbg_sup_state_type state_next;
	logic [`CBG_CNT_W-1:0]      rst_cnt_reg;
	logic [`CBG_CNT_W-1:0]      wd_cnt_reg;
	logic                       kick_prev_reg;
	logic                       kick_seen;
	logic                       access;
	logic [7:0]                 req_all;
	logic                       req_ok;
	logic [7:0]                 adc_mem [`CBG_ADC_CHANS];

	assign access    = !mreq_n_in || !iorq_n_in;
	assign kick_seen = wd_kick_in != kick_prev_reg;
	assign req_all   = {finger_req_in, foot_req_in};
	// No two requests at once, counted in hardware
	assign req_ok    = $countones(req_all) <= 1;

	// Processor clock halved from the oscillator
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			phi_out   <= 1'b0;
			phi_n_out <= 1'b1;
		end else begin
			phi_out   <= !phi_out;
			phi_n_out <= phi_out;
		end
	end

	// One-hot low selects, latched, only during an access
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			sel_n_out <= `CBG_SEL_IDLE;
		end else if (access) begin
			sel_n_out <= ~(8'h01 << addr_in);
		end else begin
			sel_n_out <= `CBG_SEL_IDLE;
		end
	end

	// Supervisor state
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			cbg_pkg::CBG_SUP_RESET: begin
				if (rst_cnt_reg == POR_LIM && !supply_fail_in) begin
					state_next = cbg_pkg::CBG_SUP_RUN;
				end
			end
			cbg_pkg::CBG_SUP_RUN: begin
				if (supply_fail_in || (wd_cnt_reg == WD_LIM && !kick_seen)) begin
					state_next = cbg_pkg::CBG_SUP_RESET;
				end
			end
		endcase
	end

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			state_reg     <= cbg_pkg::CBG_SUP_RESET;
			cpu_rst_n_out <= 1'b0;
		end else begin
			state_reg     <= state_next;
			cpu_rst_n_out <= state_next == cbg_pkg::CBG_SUP_RUN;
		end
	end

	// Reset hold timer, restarted on every entry to reset
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rst_cnt_reg <= '0;
		end else if (state_reg != cbg_pkg::CBG_SUP_RESET || supply_fail_in) begin
			rst_cnt_reg <= '0;
		end else if (rst_cnt_reg != POR_LIM) begin
			rst_cnt_reg <= rst_cnt_reg + 1'b1;
		end
	end

	// Watchdog: any change on the kick input restarts the count
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			wd_cnt_reg    <= '0;
			kick_prev_reg <= 1'b0;
		end else begin
			kick_prev_reg <= wd_kick_in;
			if (state_reg != cbg_pkg::CBG_SUP_RUN || kick_seen) begin
				wd_cnt_reg <= '0;
			end else if (wd_cnt_reg != WD_LIM) begin
				wd_cnt_reg <= wd_cnt_reg + 1'b1;
			end
		end
	end

	// Supply fail warning and battery report
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			pwr_warn_n_out <= 1'b1;
			batt_low_out   <= 1'b0;
		end else begin
			pwr_warn_n_out <= !supply_fail_in;
			batt_low_out   <= batt_low_in;
		end
	end

	// Parallel port unit: data and direction latches
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			port_out    <= `CBG_PORT_RST;
			port_oe_out <= `CBG_PORT_RST;
		end else if (port_wr_in && !port_dir_sel_in) begin
			port_out    <= port_wdata_in;
		end else if (port_wr_in && port_dir_sel_in) begin
			port_oe_out <= port_wdata_in;
		end
	end

	// Port read: inputs on undriven lines, top bit is logic supply status
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			port_rd_data_out <= `CBG_PORT_RST;
		end else begin
			port_rd_data_out <= (port_pins_in & ~port_oe_out) | (port_out & port_oe_out);
			port_rd_data_out[`CBG_PORT_STAT_B] <= logic_ok_in;
		end
	end

	// Converter scans channels in turn; results kept per channel
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			conv_chan_out <= 2'h0;
		end else if (conv_valid_in) begin
			conv_chan_out <= conv_chan_out + 2'h1;
		end
	end

	always_ff @(posedge clk_in) begin
		if (conv_valid_in) begin
			adc_mem[conv_chan_out] <= conv_data_in;
		end
	end

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			adc_rd_data_out <= 8'h00;
		end else if (conv_valid_in && conv_chan_out == adc_rd_chan_in) begin
			adc_rd_data_out <= conv_data_in;
		end else begin
			adc_rd_data_out <= adc_mem[adc_rd_chan_in];
		end
	end

	// Interlock: forwarded requests with their qualifier
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			act_out  <= 8'h00;
			safe_out <= 1'b0;
		end else begin
			act_out  <= req_all;
			safe_out <= req_ok && state_next == cbg_pkg::CBG_SUP_RUN;
		end
	end

	chk_phase_comp: assert property (@(posedge clk_in) disable iff (!nrst_in)
		phi_out != phi_n_out && (!$past(nrst_in) || phi_out != $past(phi_out)))
		else $error("clock phases not complementary halves");

	chk_sel_onehot: assert property (@(posedge clk_in) disable iff (!nrst_in)
		access |=> $countones(~sel_n_out) == 1 && !sel_n_out[$past(addr_in)])
		else $error("select not one-hot at the decoded address");

	chk_sel_idle: assert property (@(posedge clk_in) disable iff (!nrst_in)
		!access |=> sel_n_out == `CBG_SEL_IDLE)
		else $error("select active outside an access");

	chk_por_hold: assert property (@(posedge clk_in) disable iff (!nrst_in)
		$rose(cpu_rst_n_out) |-> $past(rst_cnt_reg) == POR_LIM)
		else $error("processor reset released early");

	chk_wd_expire: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(state_reg == cbg_pkg::CBG_SUP_RUN && wd_cnt_reg == WD_LIM && !kick_seen)
		|=> !cpu_rst_n_out ##1 !cpu_rst_n_out)
		else $error("watchdog expiry did not reset processor");

	chk_pfail_warn: assert property (@(posedge clk_in) disable iff (!nrst_in)
		supply_fail_in |=> !pwr_warn_n_out && !cpu_rst_n_out)
		else $error("supply failure not flagged");

	chk_batt_report: assert property (@(posedge clk_in) disable iff (!nrst_in)
		!$past(nrst_in) || batt_low_out == $past(batt_low_in))
		else $error("battery condition not reported");

	chk_supply_bit: assert property (@(posedge clk_in) disable iff (!nrst_in)
		!$past(nrst_in) || port_rd_data_out[`CBG_PORT_STAT_B] == $past(logic_ok_in))
		else $error("logic supply status missing from port");

	chk_safe_forbid: assert property (@(posedge clk_in) disable iff (!nrst_in)
		($countones(req_all) > 1) |=> !safe_out)
		else $error("safe asserted with forbidden combination");

	chk_safe_reset: assert property (@(posedge clk_in) disable iff (!nrst_in)
		!cpu_rst_n_out |-> !safe_out)
		else $error("safe asserted during supervisor reset");

	chk_port_latch: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(port_wr_in && !port_dir_sel_in) |=> port_out == $past(port_wdata_in))
		else $error("port output not latched");

	chk_port_hold: assert property (@(posedge clk_in) disable iff (!nrst_in)
		!(port_wr_in && !port_dir_sel_in) |=> $stable(port_out))
		else $error("port output changed without a write");

	chk_port_dir: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(port_wr_in && port_dir_sel_in) |=> port_oe_out == $past(port_wdata_in))
		else $error("port direction not latched");

endmodule

`default_nettype wire

// file: cbg_pkg.sv
// Types for the processor board glue logic.
// Assumes cbg_defines.svh supplies all numeric constants.
package cbg_pkg;
	typedef enum logic {
		CBG_SUP_RESET,
		CBG_SUP_RUN
	} cbg_sup_state_type;
endpackage

// file: tb_top.sv
// Bench for the board glue: a table of select and interlock cases,
// then clock, supervisor, port, converter and reset tests.
// Assumes cbg_glue and cbg_bus_model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	localparam int unsigned POR = 16;
	localparam int unsigned WD  = 64;
	typedef struct packed {
		logic [2:0] addr; logic mem; logic io;
		logic [3:0] foot; logic [3:0] finger; logic [7:0] sel_n; logic safe;
	} cbg_row_type;
	logic       clk_in, nrst_in, wd_kick_in, kick_en, supply_fail_in, batt_low_in;
	logic       logic_ok_in, port_wr_in, port_dir_sel_in, conv_valid_in;
	logic       phi_out, phi_n_out, cpu_rst_n_out, pwr_warn_n_out, batt_low_out, safe_out;
	logic       bus_mreq_n, bus_iorq_n, p;
	logic [2:0] bus_addr;
	logic [1:0] adc_rd_chan_in, conv_chan_out;
	logic [3:0] foot_req_in, finger_req_in;
	logic [7:0] port_wdata_in, port_pins_in, conv_data_in, sel_n_out, port_out, port_oe_out;
	logic [7:0] port_rd_data_out, adc_rd_data_out, act_out;
	int         failures, n_checks;
	cbg_row_type rows [9] = '{
		'{3'h0, 1'b0, 1'b1, 4'h0, 4'h0, 8'hfe, 1'b1}, '{3'h1, 1'b1, 1'b0, 4'h1, 4'h0, 8'hfd, 1'b1},
		'{3'h2, 1'b0, 1'b1, 4'h0, 4'h8, 8'hfb, 1'b1}, '{3'h3, 1'b0, 1'b1, 4'h3, 4'h0, 8'hf7, 1'b0},
		'{3'h4, 1'b1, 1'b0, 4'h1, 4'h1, 8'hef, 1'b0}, '{3'h5, 1'b0, 1'b1, 4'h0, 4'h0, 8'hdf, 1'b1},
		'{3'h6, 1'b1, 1'b0, 4'hf, 4'hf, 8'hbf, 1'b0}, '{3'h7, 1'b1, 1'b1, 4'h0, 4'h2, 8'h7f, 1'b1},
		'{3'h3, 1'b0, 1'b0, 4'h4, 4'h0, 8'hff, 1'b1}};
	cbg_bus_model bus (.clk_in, .addr_out(bus_addr), .mreq_n_out(bus_mreq_n),
		.iorq_n_out(bus_iorq_n));
	cbg_glue #(.POR_CYCLES(POR), .WD_CYCLES(WD)) DUT (.clk_in, .nrst_in,
		.addr_in(bus_addr), .mreq_n_in(bus_mreq_n), .iorq_n_in(bus_iorq_n), .wd_kick_in,
		.supply_fail_in, .batt_low_in, .logic_ok_in, .port_wr_in, .port_dir_sel_in,
		.port_wdata_in, .port_pins_in, .conv_valid_in, .conv_data_in, .adc_rd_chan_in,
		.foot_req_in, .finger_req_in, .phi_out, .phi_n_out, .sel_n_out, .cpu_rst_n_out,
		.pwr_warn_n_out, .batt_low_out, .port_out, .port_oe_out, .port_rd_data_out,
		.conv_chan_out, .adc_rd_data_out, .act_out, .safe_out);
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic complete_run();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic wait_por();
		repeat (POR - 2) @(negedge clk_in);
		check("rst_hold", cpu_rst_n_out, 8'h00);
		repeat (5) @(negedge clk_in);
		check("rst_free", cpu_rst_n_out, 8'h01);
	endtask
	task automatic step(); @(negedge clk_in); endtask
	initial begin
		clk_in = 1'b0;
		forever #20 clk_in = ~clk_in;
	end
	initial begin
		forever begin
			repeat (8) @(negedge clk_in);
			if (kick_en) wd_kick_in = ~wd_kick_in;
		end
	end
	initial begin
		repeat (5000) @(posedge clk_in);
		failures++;
		complete_run();
	end
	initial begin
		nrst_in = 0; kick_en = 1; wd_kick_in = 0; supply_fail_in = 0; batt_low_in = 0;
		logic_ok_in = 0; port_wr_in = 0; port_dir_sel_in = 0; port_wdata_in = 8'h00;
		port_pins_in = 8'ha0; conv_valid_in = 0; conv_data_in = 8'h00; adc_rd_chan_in = 2'h0;
		foot_req_in = 4'h0; finger_req_in = 4'h0;
		repeat (10) step();
		check("sel_rst", sel_n_out, 8'hff);
		nrst_in = 1;
		wait_por();
		foreach (rows[i]) begin
			bus.access(rows[i].addr, rows[i].mem, rows[i].io);
			foot_req_in = rows[i].foot;
			finger_req_in = rows[i].finger;
			step();
			check("sel_n", sel_n_out, rows[i].sel_n);
			check("safe", safe_out, rows[i].safe);
			check("act", act_out, {rows[i].finger, rows[i].foot});
		end
		p = phi_out;
		step();
		check("phi", phi_out, {7'h00, ~p});
		check("phi_n", phi_n_out, p);
		foot_req_in = 4'h0;
		kick_en = 0;
		repeat (WD - 10) step();
		check("wd_run", cpu_rst_n_out, 8'h01);
		repeat (12) step();
		check("wd_fire", cpu_rst_n_out, 8'h00);
		check("safe_rst", safe_out, 8'h00);
		kick_en = 1;
		repeat (POR + 4) step();
		check("wd_back", cpu_rst_n_out, 8'h01);
		supply_fail_in = 1;
		step();
		check("warn", pwr_warn_n_out, 8'h00);
		check("pf_rst", {cpu_rst_n_out, safe_out}, 8'h00);
		supply_fail_in = 0;
		step();
		check("warn_off", pwr_warn_n_out, 8'h01);
		wait_por();
		batt_low_in = 1;
		step();
		check("batt", batt_low_out, 8'h01);
		port_wr_in = 1; port_dir_sel_in = 1; port_wdata_in = 8'h0f;
		batt_low_in = 0;
		step();
		check("batt_ok", batt_low_out, 8'h00);
		port_dir_sel_in = 0; port_wdata_in = 8'h05;
		step();
		port_wr_in = 0;
		step();
		check("port_oe", port_oe_out, 8'h0f);
		check("port_out", port_out, 8'h05);
		step();
		check("port_rd", port_rd_data_out, 8'h25);
		logic_ok_in = 1;
		repeat (2) step();
		check("port_ok", port_rd_data_out, 8'ha5);
		conv_valid_in = 1;
		for (int i = 0; i < 4; i++) begin
			check("chan", conv_chan_out, 8'(i));
			conv_data_in = 8'(17 * (i + 1));
			step();
			check("adc_new", adc_rd_data_out, 8'h11);
		end
		conv_valid_in = 0;
		check("chan_wrap", conv_chan_out, 8'h00);
		for (int i = 0; i < 4; i++) begin
			adc_rd_chan_in = 2'(i);
			repeat (2) step();
			check("adc", adc_rd_data_out, 8'(17 * (i + 1)));
		end
		nrst_in = 0;
		step();
		check("rst_mid", {sel_n_out[3:0], port_out[3:0]}, 8'hf0);
		check("rst_safe", {cpu_rst_n_out, safe_out}, 8'h00);
		batt_low_in = 1;
		step();
		nrst_in = 1;
		wait_por();
		check("phi_rst", {phi_out, phi_n_out}, 8'h02);
		check("batt_rst", batt_low_out, 8'h01);
		complete_run();
	end
endmodule
`default_nettype wire
